// >>> rtl/snv_cfg.svh
// Constants for the serial shadowed-RAM command port
`ifndef SNV_CFG_SVH
`define SNV_CFG_SVH

// Memory shape
`define SNV_WORDS           16
`define SNV_WORD_W          16
`define SNV_ADDR_W          4
`define SNV_INSTR_W         8

// Instruction field positions
`define SNV_ADDR_MSB        6
`define SNV_ADDR_LSB        3
`define SNV_OP_MSB          2
`define SNV_OP_LSB          0

// Operation codes
`define SNV_OP_LOCK         3'h0
`define SNV_OP_SAVE         3'h1
`define SNV_OP_RESERVED     3'h2
`define SNV_OP_WRITE        3'h3
`define SNV_OP_UNLOCK       3'h4
`define SNV_OP_RELOAD       3'h5

// Reset values
`define SNV_NV_INIT         16'h0000
`define SNV_INSTR_INIT      8'h00
`define SNV_INSTR_START     8'h01

// Timing: printed times and the system clock period
`define SNV_CLK_PERIOD_NS   5
`define SNV_STORE_TIME_NS   5000000
`define SNV_RECALL_TIME_NS  2000
// Longest times, so rounded down to whole cycles
`define SNV_STORE_CYCLES    (`SNV_STORE_TIME_NS / `SNV_CLK_PERIOD_NS)
`define SNV_RECALL_CYCLES   (`SNV_RECALL_TIME_NS / `SNV_CLK_PERIOD_NS)

`endif

// >>> rtl/snv_command_port.sv
// Serial command port and nonvolatile transfer control of a 16 x 16 shadowed RAM
`timescale 1ns/1ps
`include "snv_cfg.svh"

// Behaviour
// - Chip select low clears the instruction, abandons the command, enters standby.
// - Eight-bit instruction shifts in from serial_in on shift_clock rise, MSB first.
// - Instruction is leading one, address bits 6..3, opcode bits 2..0.
// - After select rises, low input is skipped; first one is the start bit.
// - Stopped shift_clock pauses shifting with state kept; restart resumes.
// - Opcodes: 000 lock, 001 save, 010 reserved, 011 write, 100 unlock, 101 reload, 11X read.
// - Reload command or low reload pin copies nonvolatile to RAM, sets recall latch.
// - Recall latch clears at power-up; the power-up recall leaves it clear.
// - Unlock sets write-enable latch, lock clears; clear latch blocks writes and stores.
// - Write-enable latch is clear after power-up.
// - Store starts on save command or low pin, only with both latches set.
// - Store inhibits all other functions and clears write-enable when done.
// - Store finishes within 5 ms, recall within 2 us.
// - Write carries 4-bit address, then 16 data bits; host keeps select high.
// - Select dropped early during write still writes the partially shifted data.
// - Beyond 24 clocks in a write, shifting goes on, overwriting earlier bits.
// - Read ignores bit zero; first bit on eighth fall, later bits on rises.
// - Serial output is released except while read data is shifted out.
// - Legacy nap instruction is accepted and ignored.
module snv_command_port
    import snv_pkg::*;
#(
    parameter int STORE_CYCLES  = `SNV_STORE_CYCLES,
    parameter int RECALL_CYCLES = `SNV_RECALL_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic chipSelect,
    input  wire logic shiftClock,
    input  wire logic serialIn,
    input  wire logic saveReqN,
    input  wire logic reloadReqN,
    output logic      serialOut,
    output logic      serialOutEn,
    output logic      writeEnabled,
    output logic      recallDone,
    output logic      storeBusy,
    output logic      recallBusy,
    output logic      standby
);

    localparam int TMR_W = $clog2(STORE_CYCLES + 1);
    localparam int W     = `SNV_WORD_W;

    // Pin samples after synchronising
    logic [4:0]              syncOut;
    logic                    csS;
    logic                    skS;
    logic                    siS;
    logic                    saveNS;
    logic                    reloadNS;
    logic                    skPrevReg;
    logic                    skRise;
    logic                    skFall;

    // Sequencer
    snv_state_t              state_reg;
    logic [`SNV_INSTR_W-1:0] instr_reg;
    logic [2:0]              bitCnt_reg;
    logic [`SNV_ADDR_W-1:0]  addr_reg;
    logic [W-1:0]            data_reg;
    logic [4:0]              dataCnt_reg;
    logic                    gotBits_reg;
    logic [TMR_W-1:0]        timer_reg;

    // Memories
    logic [W-1:0]            ram   [`SNV_WORDS];
    logic [W-1:0]            nvMem [`SNV_WORDS];

    // Decode
    logic [`SNV_INSTR_W-1:0] instrWord;
    logic [2:0]              opCode;
    logic                    instrDone;
    logic                    readStart;
    logic                    quiet;
    logic                    timerDone;
    logic                    reloadStart;
    logic                    storeStart;
    logic                    storeFinish;
    logic                    recallFinish;
    logic                    writeCommit;
    logic                    readLast;

    // All pins cross into the clk domain through two flops
    snv_sync #(.WIDTH (5)) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({chipSelect, shiftClock, serialIn, saveReqN, reloadReqN}),
        .dout  (syncOut)
    );
    assign csS      = syncOut[4];
    assign skS      = syncOut[3];
    assign siS      = syncOut[2];
    assign saveNS   = syncOut[1];
    assign reloadNS = syncOut[0];

    // Edge finding on the synchronised shift clock; no edge, no progress
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            skPrevReg <= 1'b0;
        else
            skPrevReg <= skS;
    end
    assign skRise = skS & ~skPrevReg;
    assign skFall = ~skS & skPrevReg;

    // Instruction fields once the eighth bit arrives
    assign instrWord = {instr_reg[`SNV_INSTR_W-2:0], siS};
    assign opCode    = instrWord[`SNV_OP_MSB:`SNV_OP_LSB];
    assign instrDone = (state_reg == SNV_INSTR) && csS && skRise && (bitCnt_reg == 3'h7);
    // Read is known after seven bits, since bit zero is don't-care
    assign readStart = (state_reg == SNV_INSTR) && skRise && (bitCnt_reg == 3'h6)
                       && instr_reg[0] && siS;

    // Pins act only between commands, whatever the select level
    assign quiet = (state_reg == SNV_IDLE) || (state_reg == SNV_DONE);
    assign timerDone = (timer_reg == '0);
    // Recall wins over store when both are asked in one cycle
    assign reloadStart = (instrDone && (opCode == `SNV_OP_RELOAD))
                         || (quiet && !reloadNS);
    assign storeStart = !reloadStart
                        && ((instrDone && (opCode == `SNV_OP_SAVE)) || (quiet && !saveNS))
                        && writeEnabled && recallDone;
    assign storeFinish  = (state_reg == SNV_STORE) && timerDone;
    assign recallFinish = ((state_reg == SNV_RECALL) || (state_reg == SNV_POWERUP)) && timerDone;
    // Partial data is still written when select drops early
    assign writeCommit = (state_reg == SNV_WRITE) && !csS && gotBits_reg && writeEnabled;
    assign readLast = (state_reg == SNV_READ) && skRise && (dataCnt_reg == 5'h10);

    // Command sequencer
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg   <= SNV_POWERUP;
            instr_reg   <= `SNV_INSTR_INIT;
            bitCnt_reg  <= 3'h0;
            addr_reg    <= '0;
            data_reg    <= '0;
            dataCnt_reg <= 5'h00;
            gotBits_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                // Nonvolatile transfers ignore the serial port entirely
                SNV_POWERUP, SNV_STORE, SNV_RECALL:
                begin
                    instr_reg  <= `SNV_INSTR_INIT;
                    bitCnt_reg <= 3'h0;
                    if (timerDone)
                        state_reg <= SNV_IDLE;
                end
                default:
                begin
                    if (reloadStart)
                        state_reg <= SNV_RECALL;
                    else if (storeStart)
                        state_reg <= SNV_STORE;
                    else if (!csS)
                    begin
                        state_reg   <= SNV_IDLE;
                        instr_reg   <= `SNV_INSTR_INIT;
                        bitCnt_reg  <= 3'h0;
                        gotBits_reg <= 1'b0;
                    end
                    else
                    begin
                        case (state_reg)
                            SNV_IDLE:
                            begin
                                // Low bits before the start bit are skipped
                                if (skRise && siS)
                                begin
                                    instr_reg  <= `SNV_INSTR_START;
                                    bitCnt_reg <= 3'h1;
                                    state_reg  <= SNV_INSTR;
                                end
                            end
                            SNV_INSTR:
                            begin
                                if (skRise)
                                begin
                                    instr_reg  <= instrWord;
                                    bitCnt_reg <= bitCnt_reg + 3'h1;
                                end
                                if (readStart)
                                begin
                                    addr_reg    <= instr_reg[4:1];
                                    data_reg    <= ram[instr_reg[4:1]];
                                    dataCnt_reg <= 5'h00;
                                    state_reg   <= SNV_READ;
                                end
                                else if (instrDone)
                                begin
                                    addr_reg    <= instrWord[`SNV_ADDR_MSB:`SNV_ADDR_LSB];
                                    data_reg    <= '0;
                                    gotBits_reg <= 1'b0;
                                    // Lock, unlock, reserved and legacy codes end here
                                    if (opCode == `SNV_OP_WRITE)
                                        state_reg <= SNV_WRITE;
                                    else
                                        state_reg <= SNV_DONE;
                                end
                            end
                            SNV_WRITE:
                            begin
                                // No bit limit: extra clocks push older bits out
                                if (skRise)
                                begin
                                    data_reg    <= {data_reg[W-2:0], siS};
                                    gotBits_reg <= 1'b1;
                                end
                            end
                            SNV_READ:
                            begin
                                if (readLast)
                                    state_reg <= SNV_DONE;
                                else if (skRise)
                                begin
                                    dataCnt_reg <= dataCnt_reg + 5'h01;
                                    // Eighth rise only arms the first bit
                                    if (dataCnt_reg != 5'h00)
                                        data_reg <= {data_reg[W-2:0], 1'b0};
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Transfer timer; power-up recall starts counting out of reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            timer_reg <= TMR_W'(RECALL_CYCLES - 1);
        else if (reloadStart && quiet || reloadStart && instrDone)
            timer_reg <= TMR_W'(RECALL_CYCLES - 1);
        else if (storeStart)
            timer_reg <= TMR_W'(STORE_CYCLES - 1);
        else if (!timerDone)
            timer_reg <= timer_reg - TMR_W'(1);
    end

    // Protection latches
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            writeEnabled <= 1'b0;
            recallDone   <= 1'b0;
        end
        else
        begin
            if (storeFinish)
                writeEnabled <= 1'b0;
            else if (instrDone && (opCode == `SNV_OP_UNLOCK))
                writeEnabled <= 1'b1;
            else if (instrDone && (opCode == `SNV_OP_LOCK))
                writeEnabled <= 1'b0;
            // Only a requested recall arms stores, never the power-up one
            if (reloadStart)
                recallDone <= 1'b1;
        end
    end

    // Volatile array; recall copies every word in one cycle
    always_ff @(posedge clk)
    begin
        if (recallFinish)
            for (int i = 0; i < `SNV_WORDS; i++)
                ram[i] <= nvMem[i];
        else if (writeCommit)
            ram[addr_reg] <= data_reg;
    end

    // Nonvolatile array; reset stands for a blank first power-up
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            for (int i = 0; i < `SNV_WORDS; i++)
                nvMem[i] <= `SNV_NV_INIT;
        else if (storeFinish)
            for (int i = 0; i < `SNV_WORDS; i++)
                nvMem[i] <= ram[i];
    end

    // Serial output: first bit on a fall, the rest on rises
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
        end
        else if (state_reg != SNV_READ || !csS || readLast)
        begin
            serialOutEn <= 1'b0;
            serialOut   <= 1'b0;
        end
        else if (skFall && !serialOutEn && (dataCnt_reg == 5'h01))
        begin
            serialOutEn <= 1'b1;
            serialOut   <= data_reg[W-1];
        end
        else if (skRise && serialOutEn)
            serialOut <= data_reg[W-2];
    end

    // Status pins
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            storeBusy  <= 1'b0;
            recallBusy <= 1'b1;
            standby    <= 1'b1;
        end
        else
        begin
            storeBusy  <= (state_reg == SNV_STORE);
            recallBusy <= (state_reg == SNV_RECALL) || (state_reg == SNV_POWERUP);
            standby    <= !csS && (state_reg == SNV_IDLE);
        end
    end

endmodule

// >>> rtl/snv_pkg.sv
// Types for the serial shadowed-RAM command port
package snv_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        SNV_POWERUP,
        SNV_IDLE,
        SNV_INSTR,
        SNV_WRITE,
        SNV_READ,
        SNV_DONE,
        SNV_STORE,
        SNV_RECALL
    } snv_state_t;

endpackage

// >>> rtl/snv_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps

module snv_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            dout     <= '0;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule

// >>> tb/snv_command_port_bench.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps

module snv_command_port_bench;
    localparam int STORE  = 2000;
    localparam int RECALL = 20;

    logic        clk;
    logic        reset;
    logic        chipSelect;
    logic        shiftClock;
    logic        serialIn;
    logic        saveReqN;
    logic        reloadReqN;
    logic        serialOut;
    logic        serialOutEn;
    logic        writeEnabled;
    logic        recallDone;
    logic        storeBusy;
    logic        recallBusy;
    logic        standby;
    logic [15:0] rd;
    int          n_mismatch;
    int          n_compared;
    int          storeRun;
    int          recallRun;

    snv_command_port #(.STORE_CYCLES(STORE), .RECALL_CYCLES(RECALL)) snv_command_port_inst (
        .clk, .reset, .chipSelect, .shiftClock, .serialIn, .saveReqN, .reloadReqN,
        .serialOut, .serialOutEn, .writeEnabled, .recallDone, .storeBusy, .recallBusy, .standby
    );
    snv_host_model snv_host_model_inst (.clk, .chipSelect, .shiftClock, .serialIn, .serialOut, .serialOutEn);

    // 200 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Busy run lengths, cleared by a scenario before it starts one
    always @(posedge clk)
    begin
        if (storeBusy)
            storeRun++;
        if (recallBusy)
            recallRun++;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [2:0] op);
        snv_host_model_inst.frame({24'h00_0000, 1'b1, 4'h0, op}, 8, 0, rd);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        snv_host_model_inst.frame({8'h00, 1'b1, a, 3'b011, d}, 24, 0, rd);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic i0, input int p, input logic [15:0] exp);
        snv_host_model_inst.frame({8'h00, 1'b1, a, 2'b11, i0, 16'h0000}, 24, p, rd);
        chk("read word", exp, rd);
    endtask

    // Bounded wait for store and recall to finish
    task automatic waitIdle;
        int i;
        i = 0;
        while ((storeBusy || recallBusy) && i < 5000)
        begin
            @(posedge clk);
            i++;
        end
        #1;
        chk("idle in time", 16'h0001, 16'(i < 5000));
    endtask

    task automatic t_powerup;
        chk("recallBusy in reset", 16'h0001, 16'(recallBusy));
        chk("writeEnabled in reset", 16'h0000, 16'(writeEnabled));
        @(posedge clk);
        #1 reset = 1'b0;
        recallRun = 0;
        waitIdle;
        chk("power-up recall in time", 16'h0001, 16'(recallRun <= RECALL + 2));
        chk("recallDone after power-up", 16'h0000, 16'(recallDone));
        chk("writeEnabled after power-up", 16'h0000, 16'(writeEnabled));
        chk("standby", 16'h0001, 16'(standby));
        chk("serialOutEn", 16'h0000, 16'(serialOutEn));
    endtask

    task automatic t_locked;
        wr(4'h3, 16'h1234);
        rdchk(4'h3, 1'b0, 0, 16'h0000);
        cmd(3'b100);
        cmd(3'b001);
        chk("store without recall mark", 16'h0000, 16'(storeBusy));
        saveReqN = 1'b0;
        repeat (20) @(posedge clk);
        #1 chk("pin store without recall mark", 16'h0000, 16'(storeBusy));
        saveReqN = 1'b1;
        cmd(3'b000);
        chk("writeEnabled after lock", 16'h0000, 16'(writeEnabled));
    endtask

    task automatic t_write_read;
        cmd(3'b100);
        chk("writeEnabled after unlock", 16'h0001, 16'(writeEnabled));
        snv_host_model_inst.frame({5'h00, 3'b000, 1'b1, 4'h5, 3'b011, 16'hA5C3}, 27, 0, rd);
        rdchk(4'h5, 1'b0, 0, 16'hA5C3);
        rdchk(4'h5, 1'b1, 5, 16'hA5C3);
        cmd(3'b010);
        chk("writeEnabled after no-op", 16'h0001, 16'(writeEnabled));
        chk("recallDone after no-op", 16'h0000, 16'(recallDone));
        rdchk(4'h5, 1'b0, 0, 16'hA5C3);
        cmd(3'b000);
        wr(4'h5, 16'h0000);
        rdchk(4'h5, 1'b0, 0, 16'hA5C3);
    endtask

    task automatic t_odd_frames;
        snv_host_model_inst.frame({27'h000_0000, 5'b10101}, 5, 0, rd);
        cmd(3'b100);
        chk("unlock after abandoned frame", 16'h0001, 16'(writeEnabled));
        snv_host_model_inst.frame({20'h0_0000, 1'b1, 4'h6, 3'b011, 4'hB}, 12, 0, rd);
        rdchk(4'h6, 1'b0, 0, 16'h000B);
        snv_host_model_inst.frame({4'h0, 1'b1, 4'h7, 3'b011, 20'h1_2345}, 28, 0, rd);
        rdchk(4'h7, 1'b0, 0, 16'h2345);
    endtask

    task automatic t_store_recall;
        cmd(3'b101);
        chk("recallDone after reload", 16'h0001, 16'(recallDone));
        waitIdle;
        rdchk(4'h5, 1'b0, 0, 16'h0000);
        cmd(3'b100);
        wr(4'h5, 16'h5A3C);
        storeRun = 0;
        cmd(3'b001);
        waitIdle;
        chk("store length", 16'h0001, 16'(storeRun >= STORE - 2 && storeRun <= STORE + 2));
        chk("writeEnabled after store", 16'h0000, 16'(writeEnabled));
        cmd(3'b100);
        wr(4'h5, 16'h1111);
        recallRun  = 0;
        reloadReqN = 1'b0;
        repeat (8) @(posedge clk);
        #1 reloadReqN = 1'b1;
        waitIdle;
        chk("recall in time", 16'h0001, 16'(recallRun >= 1 && recallRun <= RECALL + 2));
        rdchk(4'h5, 1'b0, 0, 16'h5A3C);
        cmd(3'b100);
        saveReqN = 1'b0;
        repeat (8) @(posedge clk);
        #1 saveReqN = 1'b1;
        chk("pin store running", 16'h0001, 16'(storeBusy));
        waitIdle;
        chk("writeEnabled after pin store", 16'h0000, 16'(writeEnabled));
        cmd(3'b000);
    endtask

    task automatic test_done;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence: reset held four cycles, then each scenario in turn
    initial
    begin
        reset      = 1'b1;
        saveReqN   = 1'b1;
        reloadReqN = 1'b1;
        n_mismatch = 0;
        n_compared = 0;
        storeRun   = 0;
        recallRun  = 0;
        repeat (3) @(posedge clk);
        #1 t_powerup;
        t_locked;
        t_write_read;
        t_odd_frames;
        t_store_recall;
        test_done;
    end

    // Watchdog well past the expected run of about 110 us
    initial
    begin
        #400_000;
        n_mismatch++;
        test_done;
    end
endmodule

// >>> tb/snv_command_port_properties.sv
// Concurrent checks on the command port pins
`timescale 1ns/1ps

module snv_command_port_properties #(
    parameter int STORE_CYCLES  = 50,
    parameter int RECALL_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic chipSelect,
    input wire logic shiftClock,
    input wire logic serialIn,
    input wire logic saveReqN,
    input wire logic reloadReqN,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic writeEnabled,
    input wire logic recallDone,
    input wire logic storeBusy,
    input wire logic recallBusy,
    input wire logic standby
);
    int storeCnt;
    int recallCnt;

    // Busy run lengths; a sequencer that never finishes shows up here
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            storeCnt  <= 0;
            recallCnt <= 0;
        end
        else
        begin
            storeCnt  <= storeBusy ? storeCnt + 1 : 0;
            recallCnt <= recallBusy ? recallCnt + 1 : 0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Select low long enough to pass the synchroniser
    sequence selLow;
        !chipSelect [*6];
    endsequence

    a_out_parked: assert property (!serialOutEn |-> !serialOut)
        else $error("serialOut active while released");
    a_select_drop: assert property (selLow |-> !serialOutEn)
        else $error("output still enabled with select low");
    a_select_wakes: assert property (chipSelect [*5] |-> !standby)
        else $error("standby with select high");
    a_store_gate: assert property ($rose(storeBusy) |-> writeEnabled && recallDone)
        else $error("store started with a latch clear");
    a_store_unlocks: assert property ($fell(storeBusy) |-> ##[0:2] !writeEnabled)
        else $error("write enable kept after store");
    a_store_time: assert property (storeCnt <= STORE_CYCLES + 2)
        else $error("store too long");
    a_recall_time: assert property (recallCnt <= RECALL_CYCLES + 2)
        else $error("recall too long");
    a_recall_marks: assert property ($rose(recallBusy) |-> ##[0:2] recallDone)
        else $error("recall did not set its latch");
    a_busy_single: assert property (!(storeBusy && recallBusy))
        else $error("store and recall at once");
    a_mark_sticky: assert property (recallDone |=> recallDone)
        else $error("recall latch lost");
    a_read_selected: assert property ($rose(serialOutEn) |-> chipSelect && !storeBusy)
        else $error("output enabled outside a read");
endmodule

bind snv_command_port snv_command_port_properties #(
    .STORE_CYCLES  (STORE_CYCLES),
    .RECALL_CYCLES (RECALL_CYCLES)
) snv_command_port_properties_inst (
    .clk, .reset, .chipSelect, .shiftClock, .serialIn, .saveReqN, .reloadReqN,
    .serialOut, .serialOutEn, .writeEnabled, .recallDone, .storeBusy, .recallBusy, .standby
);

// >>> tb/snv_host_model.sv
// Host side of the three-wire serial link
`timescale 1ns/1ps

module snv_host_model (
    input  wire logic clk,
    output logic      chipSelect,
    output logic      shiftClock,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    // Link parked: select low, shift clock still
    initial
    begin
        chipSelect = 1'b0;
        shiftClock = 1'b0;
        serialIn   = 1'b0;
    end

    // Wait whole system cycles, then step off the edge
    task automatic half(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sends the low n bits of bits MSB first; read data is taken before rises 9 to 24
    task automatic frame(input logic [31:0] bits, input int n, input int pauseAt, output logic [15:0] rd);
        rd = 16'h0000;
        half(1);
        chipSelect = 1'b1;
        half(16);
        for (int k = 1; k <= n; k++)
        begin
            serialIn = bits[n-k];
            half(16);
            // A released line reads as pulled high, so a missing enable shows up
            if (k >= 9)
                rd = {rd[14:0], serialOutEn ? serialOut : 1'b1};
            shiftClock = 1'b1;
            half(16);
            shiftClock = 1'b0;
            if (k == pauseAt)
                half(400);
        end
        // Drop select before any further rise so no extra bit lands
        half(8);
        chipSelect = 1'b0;
        serialIn   = ~serialIn;
        half(40);
    endtask
endmodule
